// ---- rtl/rrb_consts.svh ----
`ifndef RRB_CONSTS_SVH
`define RRB_CONSTS_SVH
`define RRB_MODE_SPI_ACT_LO 4'h0
`define RRB_MODE_SPI_ACT_HI 4'h3
`define RRB_MODE_SPI_PAS_LO 4'h4
`define RRB_MODE_SPI_PAS_HI 4'h7
`define RRB_MODE_JTAG 4'hc
`define RRB_MODE_RST 4'hc
`define RRB_POR_GATE_DEFAULT 1'h0
`endif

// ---- rtl/rrb_pkg.sv ----
package rrb_pkg;
   typedef enum logic [1:0] {SRC_SPI_ACTIVE, SRC_SPI_PASSIVE, SRC_JTAG, SRC_ILLEGAL} rrb_src_t;
   typedef enum {ST_RESET, ST_RUN} rrb_state_t;
endpackage : rrb_pkg

// ---- rtl/rrb_reset_boot.sv ----
// Contract
// - Reset pin is active low; low holds reset, high permits operation.
// - Supply gate low: reset follows the reset pin alone.
// - Supply gate high: leave reset only with pin high and both supplies stable.
// - Supply gate defaults disabled when unconnected; this module has no pull of its own, the board must pull the gate low.
// - With gate enabled, any supply drop forces reset again.
// - JTAG mode: bypass JTAG to flash, no automatic start.
// - SPI active code makes device load from flash as bus controller.
// - Boot-source pins captured at reset release, held until next reset.
// - SPI active: reset release starts flash read on internal clock.
`timescale 1ns/1ps
`default_nettype none
`include "rrb_consts.svh"
module rrb_reset_boot
   import rrb_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic resetPin_n,
   input wire logic supplyGate,
   input wire logic coreSupplyOk,
   input wire logic clkSupplyOk,
   input wire logic [3:0] boot_source_select,
   output logic inReset_ff,
   output logic [3:0] bootMode_ff,
   output logic spiActive_ff,
   output logic spiPassive_ff,
   output logic jtagFlashBypass_ff,
   output logic autoStart_ff,
   output logic cpol_ff,
   output logic cpha_ff,
   output logic modeIllegal_ff
);
   // Undriven gate must be pulled low outside; default value documents that
   // gate default
   localparam logic GATE_DEFAULT = `RRB_POR_GATE_DEFAULT;

   function automatic rrb_src_t decodeSrc(input logic [3:0] m);
      if (m <= `RRB_MODE_SPI_ACT_HI)
         decodeSrc = SRC_SPI_ACTIVE;
      else if (m <= `RRB_MODE_SPI_PAS_HI)
         decodeSrc = SRC_SPI_PASSIVE;
      else if (m == `RRB_MODE_JTAG)
         decodeSrc = SRC_JTAG;
      else
         decodeSrc = SRC_ILLEGAL;
   endfunction : decodeSrc

   logic holdReq;
   logic supplyBad;
   logic releaseNow;
   logic syncA_ff;
   logic syncB_ff;
   rrb_state_t state_ff;
   rrb_src_t src;

   // drop re-entry
   // Either supply low counts, no order between them
   assign supplyBad = !(coreSupplyOk && clkSupplyOk);

   assign holdReq = !resetPin_n || ((supplyGate != GATE_DEFAULT) && supplyBad);

   // single release term
   // Shared so state, flags and capture move together
   assign releaseNow = (state_ff == ST_RESET) && syncB_ff && !holdReq;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         syncA_ff <= 1'h0;
         syncB_ff <= 1'h0;
      end
      else
      begin
         syncA_ff <= !holdReq;
         syncB_ff <= syncA_ff && !holdReq;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         state_ff <= ST_RESET;
      else
      begin
         unique case (state_ff)
            ST_RESET: if (releaseNow) state_ff <= ST_RUN;
            ST_RUN: if (holdReq) state_ff <= ST_RESET;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         inReset_ff <= 1'h1;
      else
         inReset_ff <= !releaseNow && (state_ff == ST_RESET || holdReq);
   end

   assign src = decodeSrc(boot_source_select);

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bootMode_ff <= `RRB_MODE_RST;
         spiActive_ff <= 1'h0;
         spiPassive_ff <= 1'h0;
         jtagFlashBypass_ff <= 1'h0;
         modeIllegal_ff <= 1'h0;
         cpol_ff <= 1'h0;
         cpha_ff <= 1'h0;
      end
      else if (releaseNow)
      begin
         bootMode_ff <= boot_source_select;
         spiActive_ff <= (src == SRC_SPI_ACTIVE);
         spiPassive_ff <= (src == SRC_SPI_PASSIVE);
         jtagFlashBypass_ff <= (src == SRC_JTAG);
         modeIllegal_ff <= (src == SRC_ILLEGAL);
         cpol_ff <= boot_source_select[1];
         cpha_ff <= boot_source_select[0];
      end
   end

   // start flash read
   // Pulse on each release with an SPI active code; JTAG never auto starts
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         autoStart_ff <= 1'h0;
      else
         autoStart_ff <= releaseNow && (src == SRC_SPI_ACTIVE);
   end

   pinHold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !resetPin_n |=> inReset_ff) else $error("reset pin low did not hold reset");

   gateOff_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (resetPin_n && !supplyGate) [*4] |=> !inReset_ff) else $error("gate off release blocked");

   gateOn_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      supplyGate && !coreSupplyOk |=> inReset_ff) else $error("core supply bad but out of reset");

   gateOnClk_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      supplyGate && !clkSupplyOk |=> inReset_ff) else $error("clock supply bad but out of reset");

   dropReenter_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !inReset_ff && supplyGate && !clkSupplyOk |=> inReset_ff) else $error("clock supply drop missed");

   coreDrop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !inReset_ff && supplyGate && !coreSupplyOk |=> inReset_ff) else $error("core supply drop missed");

   modeHold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !inReset_ff && !$fell(inReset_ff) |-> $stable(bootMode_ff)) else $error("mode changed while running");

   modeCapture_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(inReset_ff) |-> bootMode_ff == $past(boot_source_select)) else $error("mode not taken at release");

   jtagNoStart_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      jtagFlashBypass_ff |-> !autoStart_ff) else $error("auto start in jtag mode");

   jtagBypass_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(inReset_ff) |-> jtagFlashBypass_ff == (bootMode_ff == `RRB_MODE_JTAG))
      else $error("bypass flag does not match jtag code");

   oneSource_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !inReset_ff |-> $onehot({spiActive_ff, spiPassive_ff, jtagFlashBypass_ff, modeIllegal_ff}))
      else $error("decoded source not one hot");

   startRead_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      autoStart_ff |-> spiActive_ff && !inReset_ff) else $error("start without active mode");

   activeStart_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(inReset_ff) && spiActive_ff |-> autoStart_ff) else $error("active mode release without start");

   startPulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      autoStart_ff |=> !autoStart_ff) else $error("start pulse longer than one cycle");

   startOnly_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      autoStart_ff |-> $fell(inReset_ff)) else $error("start away from release");

   illegalNoStart_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      modeIllegal_ff |-> !autoStart_ff) else $error("start with illegal mode");

   syncRelease_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(inReset_ff) |-> $past(syncB_ff)) else $error("release not synchronised");

   cleanRelease_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(inReset_ff) |-> !$past(holdReq) && !$past(holdReq, 2) && !$past(holdReq, 3))
      else $error("release without three clean samples");

   holdKeep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      inReset_ff && holdReq |=> inReset_ff) else $error("left reset while hold present");
endmodule : rrb_reset_boot
`default_nettype wire

// ---- bench/rrb_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rrb_board_model (
   input wire logic core_clk,
   input wire logic req,
   input wire logic [3:0] mode,
   output logic resetPin_n,
   output logic [3:0] boot_source_select = 4'h0
);
   logic [1:0] holdCnt_ff = 2'h0;
   always_ff @(posedge core_clk)
   begin
      if (req)
      begin
         boot_source_select <= mode;
         holdCnt_ff <= 2'h3;
      end
      else if (holdCnt_ff != 2'h0)
         holdCnt_ff <= holdCnt_ff - 2'h1;
   end
   assign resetPin_n = (holdCnt_ff == 2'h0);
endmodule : rrb_board_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk = 1'h0, arst_n = 1'h0, req = 1'h0, gate = 1'h0, coreOk = 1'h0, clkOk = 1'h1;
   logic resetPin_n, inRst, sa, sp, jb, as, cpl, cph, il;
   logic [3:0] mode = 4'h0;
   logic [3:0] sel, bm;
   int n_fail = 0, check_count = 0;
   always #2 core_clk = ~core_clk;
   rrb_board_model brd (.core_clk(core_clk), .req(req), .mode(mode), .resetPin_n(resetPin_n),
      .boot_source_select(sel));
   rrb_reset_boot uut (.core_clk(core_clk), .arst_n(arst_n), .resetPin_n(resetPin_n), .supplyGate(gate),
      .coreSupplyOk(coreOk), .clkSupplyOk(clkOk), .boot_source_select(sel), .inReset_ff(inRst),
      .bootMode_ff(bm), .spiActive_ff(sa), .spiPassive_ff(sp), .jtagFlashBypass_ff(jb),
      .autoStart_ff(as), .cpol_ff(cpl), .cpha_ff(cph), .modeIllegal_ff(il));
   task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task print_verdict;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   // Bounded wait, a hang ends the run
   task waitRst(input logic e);
      int i;
      for (i = 0; i < 16 && inRst !== e; i++)
         tick(1);
      chk("inReset", {3'h0, e}, {3'h0, inRst});
      if (inRst !== e)
         print_verdict();
   endtask : waitRst
   task boot(input logic [3:0] m);
      @(posedge core_clk) mode <= m;
      req <= 1'h1;
      @(posedge core_clk) req <= 1'h0;
      tick(1);
      chk("held", 4'h1, {3'h0, inRst});
      waitRst(1'h0);
      chk("mode", m, bm);
      chk("decode", {m < 4'h4, m[3:2] == 2'h1, m == 4'hc, m > 4'h7 && m != 4'hc}, {sa, sp, jb, il});
      chk("clkmode", {2'h0, m[1:0]}, {2'h0, cpl, cph});
      // Start pulse rises on the release edge itself
      chk("start", {3'h0, m < 4'h4}, {3'h0, as});
      tick(1);
      chk("pulse", 4'h0, {3'h0, as});
   endtask : boot
   task supply;
      @(posedge core_clk) gate <= 1'h1;
      clkOk <= 1'h0;
      coreOk <= 1'h1;
      tick(2);
      chk("drop", 4'h1, {3'h0, inRst});
      @(posedge core_clk) clkOk <= 1'h1;
      coreOk <= 1'h0;
      tick(8);
      chk("stay", 4'h1, {3'h0, inRst});
      @(posedge core_clk) coreOk <= 1'h1;
      waitRst(1'h0);
      @(posedge core_clk) coreOk <= 1'h0;
      tick(2);
      chk("coredrop", 4'h1, {3'h0, inRst});
      @(posedge core_clk) coreOk <= 1'h1;
      waitRst(1'h0);
   endtask : supply
   task resetState;
      repeat (3) @(posedge core_clk);
      #1;
      chk("rstval", 4'hc, bm);
      chk("rsthold", 4'h1, {3'h0, inRst});
   endtask : resetState
   initial
   begin
      resetState();
      @(posedge core_clk) arst_n <= 1'h1;
      boot(4'hc);
      boot(4'h3);
      boot(4'h4);
      boot(4'h6);
      boot(4'h0);
      boot(4'h9);
      supply();
      boot(4'h1);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
